/* File: hw/pcsd_port.sv */
// port with chip-select strobes and two extra external interrupts
// assumes cpu core on CORE_CLK drives the register bus and the
// external data bus flags; pins are asynchronous
// Contract
// - eight-bit port, per-pin setup, low four pins have four modes
// - function 00 gives plain quasi-bidirectional pin behaviour
// - function 01 gives read strobe on matching external reads
// - function 10 gives write strobe on matching external writes
// - function 11 strobes on matching read or write
// - each strobe pin has its own sixteen-bit base address
// - compare 00 matches all sixteen address bits
// - compare 01 ignores address bit 0
// - compare 10 ignores address bits 1 and 0
// - compare 11 compares only bits 15 to 8
// - high config register holds pin 3 then pin 2 fields
// - low config register holds pin 1 then pin 0 fields
// - pins 2 and 3 feed extra interrupts in plain mode
// - edge bit 1 detects falling edge, 0 detects low level
// - edge mode pending set by hardware, cleared on service
// - request only while enable bit set; enables at bits 2, 6
// - priority bits 7 and 3 select high priority level
// - irq control at C0, bit-addressable, edge bits at 0 and 4
// - polarity bits 7..4 make strobes active high when set
// - plain mode drives zero port data bits low and releases pins whose data bit is one
// - high base register gives bits 15-8, low gives 7-0
`timescale 1ns/1ps
module pcsd_port
    import pcsd_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic [7:0] SFR_BIT_ADDR,
    input wire logic SFR_BIT_VAL,
    input wire logic SFR_BIT_WR,
    input wire logic [15:0] XADDR,
    input wire logic XRD_N,
    input wire logic XWR_N,
    input wire logic [7:0] PORT_IN,
    output logic [7:0] PORT_OUT,
    output logic [7:0] PORT_OE_N,
    input wire logic IRQ_A_ACK,
    input wire logic IRQ_B_ACK,
    output logic IRQ_A_REQ,
    output logic IRQ_B_REQ,
    output logic IRQ_A_HIGH_PRIO,
    output logic IRQ_B_HIGH_PRIO
);

    logic [7:0] port_data_r;
    logic [7:0] cfg_low_r;
    logic [7:0] cfg_high_r;
    logic [3:0] pol_r;
    logic [7:0] base_lo_r [NPIN];
    logic [7:0] base_hi_r [NPIN];
    logic [7:0] irq_ctl_r;
    logic pend_a_r;
    logic pend_b_r;
    logic pend_a_nxt;
    logic pend_b_nxt;
    logic [7:0] in_meta_r;
    logic [7:0] in_sync_r;
    logic [7:0] in_prev_r;
    logic [7:0] irq_view;
    logic [7:0] irq_wval;
    logic irq_whit;
    logic [3:0] cfg_nib [NPIN];
    logic [NPIN-1:0] strobe_act;
    logic [NPIN-1:0] strobe_lvl;
    logic [7:0] rdata_nxt;
    logic mode_io_a;
    logic mode_io_b;
    logic fall_a;
    logic fall_b;

    // ****************************************
    // register bus helpers
    // ****************************************

    // byte write or single-bit write hitting register a
    function automatic logic hit_wr(input logic [7:0] a);
        return (SFR_WR && SFR_ADDR == a) || (SFR_BIT_WR && SFR_BIT_ADDR[7:3] == a[7:3]);
    endfunction

    // new value after a byte or bit write
    function automatic logic [7:0] merge_wr(input logic [7:0] old, input logic [7:0] a);
        logic [7:0] v;
        v = old;
        if (SFR_WR && SFR_ADDR == a)
        begin
            v = SFR_WDATA;
        end
        else if (SFR_BIT_WR && SFR_BIT_ADDR[7:3] == a[7:3])
        begin
            v[SFR_BIT_ADDR[2:0]] = SFR_BIT_VAL;
        end
        return v;
    endfunction

    // ****************************************
    // pin input synchroniser
    // ****************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            in_meta_r <= 8'hFF;
            in_sync_r <= 8'hFF;
            in_prev_r <= 8'hFF;
        end
        else
        begin
            in_meta_r <= PORT_IN;
            in_sync_r <= in_meta_r;
            in_prev_r <= in_sync_r;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************

    // port data latch, bit-addressable
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            port_data_r <= RST_PORT_DATA;
        else
            port_data_r <= merge_wr(port_data_r, ADDR_PORT_DATA);
    end

    // mode and compare fields, polarity
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            cfg_low_r <= RST_ZERO;
            cfg_high_r <= RST_ZERO;
            pol_r <= RST_POL;
        end
        else
        begin
            if (SFR_WR && SFR_ADDR == ADDR_CFG_LOW_PINS)
                cfg_low_r <= SFR_WDATA;
            if (SFR_WR && SFR_ADDR == ADDR_CFG_HIGH_PINS)
                cfg_high_r <= SFR_WDATA;
            if (SFR_WR && SFR_ADDR == ADDR_POLARITY)
                pol_r <= SFR_WDATA[7:POL_LSB];
        end
    end

    // base address pairs, one per strobe pin
    always_ff @(posedge CORE_CLK)
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            if (RST)
            begin
                base_lo_r[i] <= RST_ZERO;
                base_hi_r[i] <= RST_ZERO;
            end
            else
            begin
                if (SFR_WR && SFR_ADDR == ADDR_BASE_LOW[i])
                    base_lo_r[i] <= SFR_WDATA;
                if (SFR_WR && SFR_ADDR == ADDR_BASE_HIGH[i])
                    base_hi_r[i] <= SFR_WDATA;
            end
        end
    end

    // ****************************************
    // strobe units
    // ****************************************

    // pin 0,1 from low register, pin 2,3 from high register
    assign cfg_nib[0] = cfg_low_r[3:0];
    assign cfg_nib[1] = cfg_low_r[7:4];
    assign cfg_nib[2] = cfg_high_r[3:0];
    assign cfg_nib[3] = cfg_high_r[7:4];

    generate
        for (genvar g = 0; g < NPIN; g++)
        begin : g_pin
            pcsd_strobe_unit u_strobe (
                .clk(CORE_CLK),
                .rst(RST),
                .func(cfg_nib[g][FUNC_MSB:FUNC_LSB]),
                .cmpw(cfg_nib[g][CMP_MSB:CMP_LSB]),
                .base({base_hi_r[g], base_lo_r[g]}),
                .pol(pol_r[g]),
                .addr(XADDR),
                .rd_act(~XRD_N),
                .wr_act(~XWR_N),
                .active(strobe_act[g]),
                .level(strobe_lvl[g])
            );
        end
    endgenerate

    // ****************************************
    // pin drivers
    // ****************************************

    // strobe pins driven both ways, plain pins quasi-bidirectional
    always_comb
    begin
        PORT_OUT = port_data_r;
        PORT_OE_N = port_data_r;
        for (int i = 0; i < NPIN; i++)
        begin
            if (cfg_nib[i][FUNC_MSB:FUNC_LSB] != FUNC_IO)
            begin
                PORT_OUT[i] = strobe_lvl[i];
                PORT_OE_N[i] = 1'b0;
            end
        end
    end

    // ****************************************
    // extra external interrupts
    // ****************************************
    assign mode_io_a = cfg_nib[PIN_IRQ_A][FUNC_MSB:FUNC_LSB] == FUNC_IO;
    assign mode_io_b = cfg_nib[PIN_IRQ_B][FUNC_MSB:FUNC_LSB] == FUNC_IO;
    assign fall_a = mode_io_a & irq_ctl_r[IRQ_A_EN_BIT] & in_prev_r[PIN_IRQ_A] & ~in_sync_r[PIN_IRQ_A];
    assign fall_b = mode_io_b & irq_ctl_r[IRQ_B_EN_BIT] & in_prev_r[PIN_IRQ_B] & ~in_sync_r[PIN_IRQ_B];

    // control view with live pending flags, then write merge
    always_comb
    begin
        irq_view = irq_ctl_r;
        irq_view[IRQ_A_PEND_BIT] = pend_a_r;
        irq_view[IRQ_B_PEND_BIT] = pend_b_r;
        irq_wval = merge_wr(irq_view, ADDR_EXT_IRQ_CONTROL);
        irq_whit = hit_wr(ADDR_EXT_IRQ_CONTROL); // in a process so bus strobes are seen
    end

    // control bits other than pending
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            irq_ctl_r <= RST_ZERO;
        else if (irq_whit)
            irq_ctl_r <= irq_wval;
    end

    // pending: edge latched, level followed; detection beats clear
    always_comb
    begin
        pend_a_nxt = pend_a_r;
        if (irq_whit)
            pend_a_nxt = irq_wval[IRQ_A_PEND_BIT];
        if (IRQ_A_ACK)
            pend_a_nxt = 1'b0;
        if (fall_a)
            pend_a_nxt = 1'b1;
        if (!irq_ctl_r[IRQ_A_EDGE_BIT])
            pend_a_nxt = mode_io_a & irq_ctl_r[IRQ_A_EN_BIT] & ~in_sync_r[PIN_IRQ_A];
    end

    always_comb
    begin
        pend_b_nxt = pend_b_r;
        if (irq_whit)
            pend_b_nxt = irq_wval[IRQ_B_PEND_BIT];
        if (IRQ_B_ACK)
            pend_b_nxt = 1'b0;
        if (fall_b)
            pend_b_nxt = 1'b1;
        if (!irq_ctl_r[IRQ_B_EDGE_BIT])
            pend_b_nxt = mode_io_b & irq_ctl_r[IRQ_B_EN_BIT] & ~in_sync_r[PIN_IRQ_B];
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            pend_a_r <= 1'b0;
            pend_b_r <= 1'b0;
        end
        else
        begin
            pend_a_r <= pend_a_nxt;
            pend_b_r <= pend_b_nxt;
        end
    end

    // requests and priority levels to the interrupt controller
    assign IRQ_A_REQ = pend_a_r & irq_ctl_r[IRQ_A_EN_BIT];
    assign IRQ_B_REQ = pend_b_r & irq_ctl_r[IRQ_B_EN_BIT];
    assign IRQ_A_HIGH_PRIO = irq_ctl_r[IRQ_A_PRIO_BIT];
    assign IRQ_B_HIGH_PRIO = irq_ctl_r[IRQ_B_PRIO_BIT];

    // ****************************************
    // register read back
    // ****************************************
    always_comb
    begin
        rdata_nxt = RST_ZERO;
        case (SFR_ADDR)
            ADDR_EXT_IRQ_CONTROL: rdata_nxt = irq_view;
            ADDR_CFG_LOW_PINS: rdata_nxt = cfg_low_r;
            ADDR_CFG_HIGH_PINS: rdata_nxt = cfg_high_r;
            ADDR_PORT_DATA: rdata_nxt = in_sync_r;
            ADDR_POLARITY: rdata_nxt = {pol_r, 4'h0};
            default: rdata_nxt = RST_ZERO;
        endcase
        for (int i = 0; i < NPIN; i++)
        begin
            if (SFR_ADDR == ADDR_BASE_LOW[i])
                rdata_nxt = base_lo_r[i];
            if (SFR_ADDR == ADDR_BASE_HIGH[i])
                rdata_nxt = base_hi_r[i];
        end
    end

    // read data held until the next read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            SFR_RDATA <= RST_ZERO;
        else if (SFR_RD)
            SFR_RDATA <= rdata_nxt;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    property p_edge_set;
        fall_a && irq_ctl_r[IRQ_A_EDGE_BIT] |=> pend_a_r && IRQ_A_REQ;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not latched");
    property p_ack_clear;
        irq_ctl_r[IRQ_B_EDGE_BIT] && IRQ_B_ACK && !fall_b && !irq_whit |=> !pend_b_r;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("service did not clear");
    property p_level;
        !irq_ctl_r[IRQ_B_EDGE_BIT] && mode_io_b && irq_ctl_r[IRQ_B_EN_BIT] && !in_sync_r[PIN_IRQ_B] |=> pend_b_r;
    endproperty
    a_level: assert property (p_level) else $error("low level missed");
    property p_req_en;
        IRQ_B_REQ |-> irq_ctl_r[IRQ_B_EN_BIT];
    endproperty
    a_req_en: assert property (p_req_en) else $error("request while disabled");
    property p_no_irq_strobe;
        !mode_io_a && !irq_whit && !pend_a_r |=> !pend_a_r;
    endproperty
    a_no_irq_strobe: assert property (p_no_irq_strobe) else $error("strobe pin raised irq");
    property p_io_drive;
        cfg_low_r[3:2] == FUNC_IO |-> PORT_OUT[0] == port_data_r[0] && PORT_OE_N[0] == port_data_r[0];
    endproperty
    a_io_drive: assert property (p_io_drive) else $error("plain pin not from latch");
    property p_pol_idle;
        cfg_high_r[7:6] != FUNC_IO && !strobe_act[3] |-> PORT_OUT[3] == ~pol_r[3] && !PORT_OE_N[3];
    endproperty
    a_pol_idle: assert property (p_pol_idle) else $error("idle strobe level wrong");
    property p_strobe_in_pulse;
        strobe_act != 4'h0 |-> !XRD_N || !XWR_N;
    endproperty
    a_strobe_in_pulse: assert property (p_strobe_in_pulse) else $error("strobe outside pulse");
    property p_reset_clear;
        $past(RST) |-> cfg_low_r == 8'h00 && cfg_high_r == 8'h00 && irq_ctl_r == 8'h00 && port_data_r == 8'hFF;
    endproperty
    a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("reset state wrong");

    c_irq_edge: cover property (fall_a ##1 IRQ_A_REQ ##[1:20] IRQ_A_ACK);
    c_strobe3: cover property (strobe_act[3] && pol_r[3]);
    c_bit_write: cover property (SFR_BIT_WR && SFR_BIT_ADDR[7:3] == ADDR_EXT_IRQ_CONTROL[7:3]);

endmodule // pcsd_port

/* File: hw/pcsd_pkg.sv */
// constants for the port chip-select decoder
// assumes an 8-bit special-register bus from the local cpu core
package pcsd_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int PORT_W = 8;
    localparam int NPIN = 4;
    localparam int ADDR_W = 16;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_EXT_IRQ_CONTROL = 8'hC0;
    localparam logic [7:0] ADDR_CFG_LOW_PINS = 8'hC2;
    localparam logic [7:0] ADDR_CFG_HIGH_PINS = 8'hC3;
    localparam logic [7:0] ADDR_PORT_DATA = 8'hD8;
    localparam logic [7:0] ADDR_POLARITY = 8'hAE;
    localparam logic [7:0] ADDR_BASE_LOW [NPIN] = '{8'h84, 8'h94, 8'hAC, 8'hB4};
    localparam logic [7:0] ADDR_BASE_HIGH [NPIN] = '{8'h85, 8'h95, 8'hAD, 8'hB5};

    // ****************************************
    // ext_irq_control bit positions
    // ****************************************
    localparam int IRQ_A_EDGE_BIT = 0;
    localparam int IRQ_A_PEND_BIT = 1;
    localparam int IRQ_A_EN_BIT = 2;
    localparam int IRQ_A_PRIO_BIT = 3;
    localparam int IRQ_B_EDGE_BIT = 4;
    localparam int IRQ_B_PEND_BIT = 5;
    localparam int IRQ_B_EN_BIT = 6;
    localparam int IRQ_B_PRIO_BIT = 7;

    // ****************************************
    // pin roles and field layout
    // ****************************************
    localparam int PIN_IRQ_A = 2;
    localparam int PIN_IRQ_B = 3;
    localparam int POL_LSB = 4;
    localparam int FUNC_MSB = 3;
    localparam int FUNC_LSB = 2;
    localparam int CMP_MSB = 1;
    localparam int CMP_LSB = 0;

    // ****************************************
    // field encodings
    // ****************************************
    localparam logic [1:0] FUNC_IO = 2'h0;
    localparam logic [1:0] FUNC_RD = 2'h1;
    localparam logic [1:0] FUNC_WR = 2'h2;
    localparam logic [1:0] FUNC_RW = 2'h3;
    localparam logic [1:0] CMP_FULL = 2'h0;
    localparam logic [1:0] CMP_A15_A1 = 2'h1;
    localparam logic [1:0] CMP_A15_A2 = 2'h2;
    localparam logic [1:0] CMP_A15_A8 = 2'h3;
    localparam logic [15:0] MASK_FULL = 16'hFFFF;
    localparam logic [15:0] MASK_A15_A1 = 16'hFFFE;
    localparam logic [15:0] MASK_A15_A2 = 16'hFFFC;
    localparam logic [15:0] MASK_A15_A8 = 16'hFF00;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_PORT_DATA = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] RST_POL = 4'h0;

endpackage

/* File: hw/pcsd_strobe_unit.sv */
// one strobe-capable pin: address compare and strobe generation
// assumes rd/wr activity flags from the same clock domain
`timescale 1ns/1ps
module pcsd_strobe_unit
    import pcsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] func,
    input wire logic [1:0] cmpw,
    input wire logic [15:0] base,
    input wire logic pol,
    input wire logic [15:0] addr,
    input wire logic rd_act,
    input wire logic wr_act,
    output logic active,
    output logic level
);

    logic [15:0] mask;
    logic match;

    // ****************************************
    // compare width select
    // ****************************************
    always_comb
    begin
        case (cmpw)
            CMP_FULL: mask = MASK_FULL;
            CMP_A15_A1: mask = MASK_A15_A1;
            CMP_A15_A2: mask = MASK_A15_A2;
            CMP_A15_A8: mask = MASK_A15_A8;
            default: mask = MASK_FULL;
        endcase
    end

    assign match = ((addr ^ base) & mask) == 16'h0000;

    // ****************************************
    // strobe qualification by mode
    // ****************************************
    always_comb
    begin
        case (func)
            FUNC_RD: active = match & rd_act;
            FUNC_WR: active = match & wr_act;
            FUNC_RW: active = match & (rd_act | wr_act);
            default: active = 1'b0;
        endcase
    end

    // polarity applied at the pin
    assign level = pol ? active : ~active;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_full_cmp;
        active && cmpw == CMP_FULL |-> addr == base;
    endproperty
    a_full_cmp: assert property (p_full_cmp) else $error("full compare mismatch");
    property p_cmp_a1;
        active && cmpw == CMP_A15_A1 |-> addr[15:1] == base[15:1];
    endproperty
    a_cmp_a1: assert property (p_cmp_a1) else $error("a15-a1 compare mismatch");
    property p_cmp_a2;
        active && cmpw == CMP_A15_A2 |-> addr[15:2] == base[15:2];
    endproperty
    a_cmp_a2: assert property (p_cmp_a2) else $error("a15-a2 compare mismatch");
    property p_cmp_a8;
        cmpw == CMP_A15_A8 && func == FUNC_RW && addr[15:8] == base[15:8] && (rd_act || wr_act) |-> active;
    endproperty
    a_cmp_a8: assert property (p_cmp_a8) else $error("block match missed");
    property p_rd_only;
        active && func == FUNC_RD |-> rd_act;
    endproperty
    a_rd_only: assert property (p_rd_only) else $error("read strobe without read");
    property p_wr_only;
        active && func == FUNC_WR |-> wr_act;
    endproperty
    a_wr_only: assert property (p_wr_only) else $error("write strobe without write");
    property p_io_quiet;
        func == FUNC_IO |-> !active;
    endproperty
    a_io_quiet: assert property (p_io_quiet) else $error("strobe in plain i/o mode");

    c_rd: cover property (active && func == FUNC_RD);
    c_wr: cover property (active && func == FUNC_WR);

endmodule // pcsd_strobe_unit

/* File: testbench/pcsd_periph_model.sv */
// peripheral on the external bus, selected by one strobe pin
// assumes pin level and the polarity setting of that pin as seen by the bench
`timescale 1ns/1ps
module pcsd_periph_model
#(
    parameter logic [7:0] RESP = 8'hA5
)
(
    input wire logic cs_pin,
    input wire logic cs_high,
    input wire logic rd_n,
    output logic [7:0] rdata
);
    logic sel;

    // answers only while selected during a read pulse
    assign sel = (cs_high ? cs_pin : !cs_pin) && !rd_n;
    // released bus shows the fixed inverse of RESP, the response value
    assign rdata = sel ? RESP : ~RESP;
endmodule // pcsd_periph_model

/* File: testbench/pcsd_port_tb.sv */
// self-checking bench for the port chip-select decoder
// assumes the design top pcsd_port and the peripheral model
`timescale 1ns/1ps
module pcsd_port_tb
    import pcsd_pkg::*;
;
    logic core_clk, rst, sfr_wr, sfr_rd, sfr_bit_val, sfr_bit_wr, xrd_n, xwr_n, ack_a, ack_b;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, ext_in, pin_lvl, port_out, port_oe_n;
    logic [15:0] xaddr;
    logic irq_a_req, irq_b_req, prio_a, prio_b, pol_sel;
    logic [1:0] pin_sel;
    logic [7:0] per_data;
    logic [31:0] r, s;
    int failures, samples_checked;

    // ****************************************
    // clock, pins and instances
    // ****************************************
    always #4 core_clk = ~core_clk;
    // pin level from driver enable, else external level
    assign pin_lvl = (~port_oe_n & port_out) | (port_oe_n & ext_in);

    pcsd_port u_pcsd_port (.CORE_CLK(core_clk), .RST(rst), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .SFR_BIT_ADDR(sfr_bit_addr),
        .SFR_BIT_VAL(sfr_bit_val), .SFR_BIT_WR(sfr_bit_wr), .XADDR(xaddr), .XRD_N(xrd_n), .XWR_N(xwr_n),
        .PORT_IN(pin_lvl), .PORT_OUT(port_out), .PORT_OE_N(port_oe_n), .IRQ_A_ACK(ack_a), .IRQ_B_ACK(ack_b),
        .IRQ_A_REQ(irq_a_req), .IRQ_B_REQ(irq_b_req), .IRQ_A_HIGH_PRIO(prio_a), .IRQ_B_HIGH_PRIO(prio_b));

    pcsd_periph_model u_pcsd_periph_model (.cs_pin(port_out[pin_sel]), .cs_high(pol_sel), .rd_n(xrd_n),
        .rdata(per_data));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // address hit and matching pulse for one strobe pin
    function automatic logic hit(input logic [1:0] f, input logic [1:0] c, input logic [15:0] b,
                                 input logic [15:0] a, input logic rdn, input logic wrn);
        logic [15:0] m;
        m = (c == 2'h0) ? 16'hFFFF : (c == 2'h1) ? 16'hFFFE : (c == 2'h2) ? 16'hFFFC : 16'hFF00;
        return ((a & m) == (b & m)) && ((f[0] && !rdn) || (f[1] && !wrn));
    endfunction

    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic bw(input logic [7:0] a, input logic v);
        @(posedge core_clk);
        sfr_bit_addr <= a;
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge core_clk);
        sfr_bit_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        @(negedge core_clk);
        chk(16'(sfr_rdata), 16'(e));
    endtask

    // bounded wait for a request line to reach a level
    task automatic wt(input logic b, input logic v);
        int i;
        for (i = 0; i < 10 && (b ? irq_b_req : irq_a_req) !== v; i++)
            @(negedge core_clk);
        if (i == 10)
        begin
            failures++;
            test_done();
        end
    endtask

    // set up one strobe pin, run one bus pulse, check pin and peripheral
    task automatic stb(input logic [1:0] p, input logic [1:0] f, input logic [1:0] c, input logic [15:0] b,
                       input logic pl, input logic [15:0] a, input logic rdn, input logic wrn);
        logic [7:0] cfg;
        logic act;
        cfg = 8'({f, c}) << (4 * p[0]);
        act = (f != 2'h0) && hit(f, c, b, a, rdn, wrn);
        pin_sel = p;
        pol_sel = pl & (f != 2'h0); // plain pin idles high, so peripheral is active low there
        wr(p[1] ? 8'hC3 : 8'hC2, cfg);
        wr(ADDR_BASE_HIGH[p], b[15:8]);
        wr(ADDR_BASE_LOW[p], b[7:0]);
        wr(8'hAE, 8'(pl) << (4 + p));
        rdc(p[1] ? 8'hC3 : 8'hC2, cfg);
        rdc(ADDR_BASE_HIGH[p], b[15:8]);
        rdc(8'hAE, 8'(pl) << (4 + p));
        @(posedge core_clk);
        xaddr <= a;
        xrd_n <= rdn;
        xwr_n <= wrn;
        @(negedge core_clk);
        chk(16'(port_out[p]), 16'((f == 2'h0) ? 1'b1 : (pl ? act : !act)));
        chk(16'(per_data), 16'((act && !rdn) ? 8'hA5 : 8'h5A));
        @(posedge core_clk);
        xrd_n <= 1'b1;
        xwr_n <= 1'b1;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        core_clk = 0; rst = 1; sfr_wr = 0; sfr_rd = 0; sfr_bit_val = 0; sfr_bit_wr = 0;
        sfr_addr = 0; sfr_wdata = 0; sfr_bit_addr = 0; xaddr = 0; xrd_n = 1; xwr_n = 1;
        ext_in = 8'hFF; ack_a = 0; ack_b = 0; pin_sel = 0; pol_sel = 0; r = 32'hFEBF;
        failures = 0; samples_checked = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({port_out, port_oe_n}, 16'hFFFF);
        rdc(8'hC2, 8'h00);
        rdc(8'hC3, 8'h00);
        rdc(8'hC0, 8'h00);
        rdc(ADDR_BASE_LOW[3], 8'h00);
        rdc(8'h81, 8'h00);
        rdc(8'hD8, 8'hFF);
        wr(8'hD8, 8'h5A);
        @(negedge core_clk);
        chk({port_out, port_oe_n}, 16'h5A5A);
        bw(8'hD8, 1'b1);
        repeat (3) @(negedge core_clk);
        rdc(8'hD8, 8'h5B);
        wr(8'hD8, 8'hFF);
        // hand-written strobe corners
        stb(0, 2'h2, 2'h2, 16'h1234, 1, 16'h1237, 1, 0);
        stb(0, 2'h2, 2'h2, 16'h1234, 1, 16'h1238, 1, 0);
        stb(1, 2'h1, 2'h0, 16'hFFFF, 0, 16'hFFFF, 0, 1);
        stb(1, 2'h1, 2'h0, 16'hFFFF, 0, 16'hFFFF, 1, 0);
        stb(2, 2'h3, 2'h1, 16'h8001, 1, 16'h8000, 1, 0);
        stb(3, 2'h3, 2'h3, 16'hAB00, 1, 16'hABFF, 0, 1);
        stb(3, 2'h2, 2'h3, 16'hAB00, 0, 16'hAC00, 1, 0);
        // random strobe setups and bus pulses
        repeat (40)
        begin
            r = xs(r);
            s = xs(r);
            stb(r[1:0], r[3:2], r[5:4], r[31:16], r[6],
                s[8] ? s[31:16] : (r[31:16] ^ (16'(s[7:0]) >> s[11:9])), s[12], !s[12] | s[13]);
            r = s;
        end
        // extra interrupts on pins 2 and 3
        wr(8'hC2, 8'h00);
        wr(8'hC3, 8'h00);
        wr(8'hC0, 8'h01);
        @(posedge core_clk);
        ext_in[2] <= 1'b0;
        repeat (8) @(negedge core_clk);
        chk(16'(irq_a_req), 16'h0);
        @(posedge core_clk);
        ext_in[2] <= 1'b1;
        repeat (4) @(negedge core_clk);
        wr(8'hC0, 8'h05);
        @(posedge core_clk);
        ext_in[2] <= 1'b0;
        wt(0, 1);
        chk(16'(irq_a_req), 16'h1);
        rdc(8'hC0, 8'h07);
        @(posedge core_clk);
        ack_a <= 1'b1;
        @(posedge core_clk);
        ack_a <= 1'b0;
        @(negedge core_clk);
        chk(16'(irq_a_req), 16'h0);
        repeat (6) @(negedge core_clk);
        chk(16'(irq_a_req), 16'h0);
        @(posedge core_clk);
        ext_in[2] <= 1'b1;
        bw(8'hC6, 1'b1);
        bw(8'hC7, 1'b1);
        bw(8'hC3, 1'b1);
        @(negedge core_clk);
        chk(16'({prio_a, prio_b}), 16'h3);
        rdc(8'hC0, 8'hCD);
        @(posedge core_clk);
        ext_in[3] <= 1'b0;
        wt(1, 1);
        chk(16'(irq_b_req), 16'h1);
        @(posedge core_clk);
        ext_in[3] <= 1'b1;
        wt(1, 0);
        chk(16'(irq_b_req), 16'h0);
        // edge mode on irq b, then service pulse
        bw(8'hC4, 1'b1);
        @(posedge core_clk);
        ext_in[3] <= 1'b0;
        wt(1, 1);
        chk(16'(irq_b_req), 16'h1);
        @(posedge core_clk);
        ack_b <= 1'b1;
        @(posedge core_clk);
        ack_b <= 1'b0;
        @(negedge core_clk);
        chk(16'(irq_b_req), 16'h0);
        test_done();
    end
endmodule // pcsd_port_tb
